// file: shared/port_pkg.sv
package port_pkg;

  // ---------------------------------------------------------------
  // Register map (word offsets in bytes)
  // ---------------------------------------------------------------
  localparam logic [7:0] PE_PULLUP_OFS  = 8'h00;
  localparam logic [7:0] PE_SLEW_OFS    = 8'h04;
  localparam logic [7:0] PE_PULLDN_OFS  = 8'h08;
  localparam logic [7:0] PG_DATA_OFS    = 8'h10;
  localparam logic [7:0] PG_DIR_OFS     = 8'h14;
  localparam logic [7:0] PG_DRIVE_OFS   = 8'h18;

  // ---------------------------------------------------------------
  // Widths and field positions
  // ---------------------------------------------------------------
  localparam int PE_WIDTH        = 8;
  localparam int PG_WIDTH        = 6;
  localparam int PE_INPUT_ONLY   = 1;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] PE_PULLUP_RST = 8'h00;
  localparam logic [7:0] PE_SLEW_RST   = 8'h00;
  localparam logic [7:0] PE_PULLDN_RST = 8'h00;
  localparam logic [5:0] PG_DATA_RST   = 6'h00;
  localparam logic [5:0] PG_DIR_RST    = 6'h00;
  localparam logic [5:0] PG_DRIVE_RST  = 6'h00;

  // Bus slave states
  typedef enum logic [0:0] {
    BUS_IDLE,
    BUS_DONE
  } bus_state_t;

endpackage : port_pkg

// file: shared/reg_write_if.sv
// Register write strobes from the bus slave to the register store
interface reg_write_if;
  logic       wrStrobe;
  logic [7:0] wrAddr;
  logic [7:0] wrData;

  modport source (output wrStrobe, output wrAddr, output wrData);
  modport sink   (input  wrStrobe, input  wrAddr, input  wrData);
endinterface : reg_write_if

// file: test/pin_board_model.sv
// Board side of the port G pins
module pin_board_model (
  input  wire logic       clock,
  input  wire logic [5:0] drvOut,
  input  wire logic [5:0] drvOe,
  input  wire logic [5:0] boardVal,
  input  wire logic [5:0] boardEn,
  output logic      [5:0] pinLevel
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] lastReg;

  // Floating pins show the inverse of the last level, so a stale value never passes
  assign pinLevel = (drvOe & drvOut) | (~drvOe & boardEn & boardVal)
                  | (~drvOe & ~boardEn & ~lastReg);

  // Memory of the previous wire level
  always_ff @(posedge clock) lastReg <= pinLevel;
endmodule : pin_board_model

// file: test/port_pin_control_registers_tb.sv
module port_pin_control_registers_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import port_pkg::*;
  logic        clock = 0, arst_n = 0, read = 0, write = 0, waitrequest;
  logic [7:0]  address = 8'h00, portEDir = 8'h00, portEIntEnable = 8'h00;
  logic [7:0]  portEEdgeRising = 8'h00, portEPullUpOn, portEPullDownOn, portESlewOn;
  logic [31:0] writedata = 32'h0000_0000, readdata, rd;
  logic [5:0]  pinIn, pinOut, pinOe, highDrive, boardVal = 6'h15, boardEn = 6'h3F;
  int          bad_count = 0, cmp_count = 0;

  always #5 clock = ~clock;

  port_pin_control_registers dut_u (.clock(clock), .arst_n(arst_n), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .portEDir(portEDir), .portEIntEnable(portEIntEnable),
    .portEEdgeRising(portEEdgeRising), .portEPullUpOn(portEPullUpOn),
    .portEPullDownOn(portEPullDownOn), .portESlewOn(portESlewOn), .portGPinIn(pinIn),
    .portGPinOut(pinOut), .portGPinOe(pinOe), .portGHighDrive(highDrive));

  pin_board_model board_u (.clock(clock), .drvOut(pinOut), .drvOe(pinOe),
    .boardVal(boardVal), .boardEn(boardEn), .pinLevel(pinIn));

  // ---------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus_cycle(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clock);
    address   <= a;
    write     <= w;
    read      <= ~w;
    writedata <= d;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (waitrequest === 1'b0) break;
    end
    if (n == 50) bad_count++;
    rd = readdata;
    write <= 1'b0;
    read  <= 1'b0;
  endtask : bus_cycle

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus_cycle(a, 1'b0, 32'h0000_0000);
    check(rd, exp);
  endtask : rd_chk

  // Pads follow a write one cycle later; sample clear of the edge
  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask : settle

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report

  task automatic reset_checks();
    rd_chk(PE_PULLUP_OFS, 32'h0000_0000);
    rd_chk(PE_SLEW_OFS, 32'h0000_0000);
    rd_chk(PG_DIR_OFS, 32'h0000_0000);
    rd_chk(PG_DRIVE_OFS, 32'h0000_0000);
    check({26'h0, pinOe}, 32'h0000_0000);
    check({24'h0, portEPullUpOn}, 32'h0000_0000);
  endtask : reset_checks

  // ---------------------------------------------------------------
  // Watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge clock);
    bad_count++;
    final_report();
  end

  initial begin
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    reset_checks();
    boardEn <= 6'h00;
    rd_chk(8'h0C, 32'h0000_0000);  // Unmapped reads zero
    bus_cycle(8'h0C, 1'b1, 32'h0000_00FF);
    rd_chk(8'h0C, 32'h0000_0000);
    $display("test reset done");
    // Pull-up, output override and pull-down selection
    bus_cycle(PE_PULLUP_OFS, 1'b1, 32'h0000_00B5);
    settle();
    check({24'h0, portEPullUpOn}, 32'h0000_00B5);
    @(posedge clock);
    portEDir <= 8'h0F;
    bus_cycle(PE_PULLDN_OFS, 1'b1, 32'h0000_00FF);
    portEIntEnable  <= 8'h30;
    portEEdgeRising <= 8'h10;
    settle();
    check({24'h0, portEPullUpOn}, 32'h0000_00A0);
    check({24'h0, portEPullDownOn}, 32'h0000_0010);
    $display("test pull done");
    // Slew limiting, bit 1 dead
    @(posedge clock);
    portEDir <= 8'hFF;
    bus_cycle(PE_SLEW_OFS, 1'b1, 32'hFFFF_FFFF);
    settle();
    check({24'h0, portESlewOn}, 32'h0000_00FD);
    check({24'h0, portEPullUpOn | portEPullDownOn}, 32'h0000_0000);
    rd_chk(PE_SLEW_OFS, 32'h0000_00FF);
    $display("test slew done");
    // Port G data, direction and drive
    @(posedge clock);
    boardEn <= 6'h3F;
    bus_cycle(PG_DATA_OFS, 1'b1, 32'h0000_002A);
    settle();
    check({26'h0, pinOe}, 32'h0000_0000);
    rd_chk(PG_DATA_OFS, 32'h0000_0015);
    bus_cycle(PG_DIR_OFS, 1'b1, 32'h0000_000F);
    settle();
    check({26'h0, pinOe}, 32'h0000_000F);
    check({26'h0, pinIn & pinOe}, 32'h0000_000A);
    rd_chk(PG_DATA_OFS, 32'h0000_001A);
    bus_cycle(PG_DATA_OFS, 1'b1, 32'hFFFF_FFFF);
    rd_chk(PG_DATA_OFS, 32'h0000_001F);
    bus_cycle(PG_DRIVE_OFS, 1'b1, 32'h0000_0005);
    settle();
    check({26'h0, highDrive & pinOe}, 32'h0000_0005);
    rd_chk(PG_DRIVE_OFS, 32'h0000_0005);
    $display("test port g done");
    // Second reset in mid-run
    arst_n <= 1'b0;
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    reset_checks();
    bus_cycle(PG_DIR_OFS, 1'b1, 32'h0000_003F);
    settle();
    check({26'h0, pinOut}, 32'h0000_0000);
    $display("test second reset done");
    final_report();
  end
endmodule : port_pin_control_registers_tb

// file: verilog/avalon_slave.sv
// Avalon-MM slave front end: one wait state, then a one-cycle answer
module avalon_slave
  import port_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [7:0]  rdValue,
  output logic             waitrequest,
  output logic [31:0]      readdata,
  reg_write_if.source      wr
);
  import port_pkg::*;

  bus_state_t stateReg;

  // ---------------------------------------------------------------
  // Handshake
  // ---------------------------------------------------------------
  // Waitrequest high while idle so the request is always seen once
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stateReg    <= BUS_IDLE;
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end else begin
      case (stateReg)
        BUS_IDLE: begin
          if (read || write) begin
            stateReg    <= BUS_DONE;
            waitrequest <= 1'b0;
            readdata    <= {24'h00_0000, rdValue};
          end
        end
        default: begin
          stateReg    <= BUS_IDLE;
          waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // Write lands on the edge the master sees waitrequest low
  assign wr.wrStrobe = write && !waitrequest;
  assign wr.wrAddr   = address;
  assign wr.wrData   = writedata[7:0];

endmodule : avalon_slave

// file: verilog/pin_latch.sv
// Per-pin data latch with direction-steered readback
module pin_latch #(
  parameter int WIDTH = 6
) (
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] loadData,
  input  wire logic [WIDTH-1:0] pinLevel,
  input  wire logic [WIDTH-1:0] dirBits,
  output logic      [WIDTH-1:0] latchValue,
  output logic      [WIDTH-1:0] readValue
);

  // Latch takes every bit whatever the direction
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      latchValue <= '0;
    end else if (load) begin
      latchValue <= loadData;
    end
  end

  // Output bits read the latch, input bits read the pin
  assign readValue = (dirBits & latchValue) | (~dirBits & pinLevel);

endmodule : pin_latch

// file: verilog/port_pin_control_registers.sv
module port_pin_control_registers
  import port_pkg::*;
#(
  parameter int PE_PINS = port_pkg::PE_WIDTH,
  parameter int PG_PINS = port_pkg::PG_WIDTH
) (
  input  wire logic               clock,
  input  wire logic               arst_n,
  input  wire logic [7:0]         address,
  input  wire logic               read,
  input  wire logic               write,
  input  wire logic [31:0]        writedata,
  output logic      [31:0]        readdata,
  output logic                    waitrequest,
  input  wire logic [PE_PINS-1:0] portEDir,
  input  wire logic [PE_PINS-1:0] portEIntEnable,
  input  wire logic [PE_PINS-1:0] portEEdgeRising,
  output logic      [PE_PINS-1:0] portEPullUpOn,
  output logic      [PE_PINS-1:0] portEPullDownOn,
  output logic      [PE_PINS-1:0] portESlewOn,
  input  wire logic [PG_PINS-1:0] portGPinIn,
  output logic      [PG_PINS-1:0] portGPinOut,
  output logic      [PG_PINS-1:0] portGPinOe,
  output logic      [PG_PINS-1:0] portGHighDrive
);
  import port_pkg::*;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [PE_PINS-1:0] pullupEnable_reg;
  logic [PE_PINS-1:0] slewEnable_reg;
  logic [PE_PINS-1:0] pulldownSelect_reg;
  logic [PG_PINS-1:0] direction_reg;
  logic [PG_PINS-1:0] driveSelect_reg;
  logic [PG_PINS-1:0] dataLatch;
  logic [PG_PINS-1:0] dataRead;
  logic [7:0]         rdValue;

  reg_write_if wrBus ();

  // Write hit on a register offset
  function automatic logic hit(input logic [7:0] ofs);
    return wrBus.wrStrobe && (wrBus.wrAddr == ofs);
  endfunction : hit

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  avalon_slave busSlave (
    .clock       (clock),
    .arst_n      (arst_n),
    .address     (address),
    .read        (read),
    .write       (write),
    .writedata   (writedata),
    .rdValue     (rdValue),
    .waitrequest (waitrequest),
    .readdata    (readdata),
    .wr          (wrBus.source)
  );

  // Port E pull enable and pull polarity selection
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pullupEnable_reg   <= PE_PULLUP_RST;
      pulldownSelect_reg <= PE_PULLDN_RST;
    end else begin
      if (hit(PE_PULLUP_OFS)) begin
        pullupEnable_reg <= wrBus.wrData[PE_PINS-1:0];
      end
      if (hit(PE_PULLDN_OFS)) begin
        pulldownSelect_reg <= wrBus.wrData[PE_PINS-1:0];
      end
    end
  end

  // Port E slew control; zero at reset, software should still set it
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      slewEnable_reg <= PE_SLEW_RST;
    end else if (hit(PE_SLEW_OFS)) begin
      slewEnable_reg <= wrBus.wrData[PE_PINS-1:0];
    end
  end

  // Port G direction and drive strength
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      direction_reg   <= PG_DIR_RST;
      driveSelect_reg <= PG_DRIVE_RST;
    end else begin
      if (hit(PG_DIR_OFS)) begin
        direction_reg <= wrBus.wrData[PG_PINS-1:0];
      end
      if (hit(PG_DRIVE_OFS)) begin
        driveSelect_reg <= wrBus.wrData[PG_PINS-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Port G data latch
  // ---------------------------------------------------------------
  pin_latch #(
    .WIDTH (PG_PINS)
  ) dataStore (
    .clock      (clock),
    .arst_n     (arst_n),
    .load       (hit(PG_DATA_OFS)),
    .loadData   (wrBus.wrData[PG_PINS-1:0]),
    .pinLevel   (portGPinIn),
    .dirBits    (direction_reg),
    .latchValue (dataLatch),
    .readValue  (dataRead)
  );

  // Read mux; unmapped offsets read as zero
  always_comb begin
    rdValue = 8'h00;
    if (address == PE_PULLUP_OFS) begin
      rdValue[PE_PINS-1:0] = pullupEnable_reg;
    end else if (address == PE_SLEW_OFS) begin
      rdValue[PE_PINS-1:0] = slewEnable_reg;
    end else if (address == PE_PULLDN_OFS) begin
      rdValue[PE_PINS-1:0] = pulldownSelect_reg;
    end else if (address == PG_DATA_OFS) begin
      rdValue[PG_PINS-1:0] = dataRead;
    end else if (address == PG_DIR_OFS) begin
      rdValue[PG_PINS-1:0] = direction_reg;
    end else if (address == PG_DRIVE_OFS) begin
      rdValue[PG_PINS-1:0] = driveSelect_reg;
    end
  end

  // ---------------------------------------------------------------
  // Pad controls, all registered
  // ---------------------------------------------------------------
  // Port E pulls; output pins force both off, pull-down only with irq edge
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      portEPullUpOn   <= '0;
      portEPullDownOn <= '0;
    end else begin
      for (int i = 0; i < PE_PINS; i++) begin
        logic on;
        logic down;
        on   = pullupEnable_reg[i] && !portEDir[i];
        down = portEIntEnable[i] && pulldownSelect_reg[i]
               && portEEdgeRising[i];
        portEPullUpOn[i]   <= on && !down;
        portEPullDownOn[i] <= on && down;
      end
    end
  end

  // Port E slew; input pins and the input-only pin get none
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      portESlewOn <= '0;
    end else begin
      portESlewOn <= slewEnable_reg & portEDir;
      portESlewOn[PE_INPUT_ONLY] <= 1'b0;
    end
  end

  // Port G drivers follow direction; drive strength only on outputs
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      portGPinOut    <= '0;
      portGPinOe     <= '0;
      portGHighDrive <= '0;
    end else begin
      portGPinOut    <= dataLatch;
      portGPinOe     <= direction_reg;
      portGHighDrive <= driveSelect_reg & direction_reg;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  pull_out_off_a: assert property (@(posedge clock) disable iff (!arst_n)
    portEDir == $past(portEDir) |=> (portEPullUpOn & $past(portEDir)) == '0
  ) else $error("pull on for output pin");

  pullup_follows_a: assert property (@(posedge clock) disable iff (!arst_n)
    (!portEDir[0] && !portEIntEnable[0] && pullupEnable_reg[0]) |=> portEPullUpOn[0]
  ) else $error("pull-up not applied");

  pulldown_gate_a: assert property (@(posedge clock) disable iff (!arst_n)
    !(portEIntEnable[0] && portEEdgeRising[0]) |=> !portEPullDownOn[0]
  ) else $error("pull-down without interrupt setup");

  slew_input_a: assert property (@(posedge clock) disable iff (!arst_n)
    1'b1 |=> (portESlewOn & ~$past(portEDir)) == '0
  ) else $error("slew on input pin");

  slew_bit1_a: assert property (@(posedge clock) disable iff (!arst_n)
    !portESlewOn[PE_INPUT_ONLY]
  ) else $error("slew on input-only pin");

  data_drive_a: assert property (@(posedge clock) disable iff (!arst_n)
    hit(PG_DATA_OFS) |=> ##1 portGPinOut == $past(wrBus.wrData[PG_PINS-1:0], 2)
  ) else $error("latched data not driven");

  dir_enable_a: assert property (@(posedge clock) disable iff (!arst_n)
    hit(PG_DIR_OFS) |=> ##1 portGPinOe == $past(wrBus.wrData[PG_PINS-1:0], 2)
  ) else $error("driver enable wrong");

  drive_input_a: assert property (@(posedge clock) disable iff (!arst_n)
    1'b1 |=> (portGHighDrive & ~$past(direction_reg)) == '0
  ) else $error("high drive on input");

  read_mix_a: assert property (@(posedge clock) disable iff (!arst_n)
    address == PG_DATA_OFS |-> rdValue[PG_PINS-1:0] ==
      ((direction_reg & dataLatch) | (~direction_reg & portGPinIn))
  ) else $error("data read mix wrong");

endmodule : port_pin_control_registers
